// File: hw/hrs_home_return_sequencer.sv
// hrs_home_return_sequencer: home-return sequencing for one pulse-train axis
// assumes sensor inputs synchronous to core_clk; limits are high while clear
`timescale 1ns/10ps
//
// Contract
// - zero after dog release during decel stops
// - home-side limit before dog on in dog method starts retry
// - opposite limit decelerates axis to stop
// - dog on at start: creep, no retry
// - start ramps bias to home speed
// - dog on decelerates to creep speed
// - stopper-1 dwell expiry stops, emits clear
// - clear pulse 10 ms, then flags update
// - dwell expiry completes even above creep
// - stopper methods with dog on: creep
// - no retry in stopper methods
// - stopper-2 zero stops pulses, emits clear
// - first zero after dog release completes
// - stop causes use stop deceleration step
// - stopper-2 start with zero on: error
// - stopper-2 early zero completes at once
module hrs_home_return_sequencer
    import hrs_pkg::*;
#(
    parameter int MS_CYC    = MS_CYC_DEF,
    parameter int CLEAR_CYC = CLEAR_CYC_DEF
) (
    input  wire logic        core_clk,     // 50 MHz clock
    input  wire logic        srst,         // sync reset, active high
    input  wire logic [3:0]  regAddr,      // register word index
    input  wire logic [31:0] regWdata,     // write data
    input  wire logic        regWr,        // write strobe
    input  wire logic        regRd,        // read strobe
    output logic      [31:0] regRdata,     // read data, cycle after strobe
    input  hrs_sens_t        sensIn,       // dog, zero, limits, ready, stop
    output logic             pulseOut,     // pulse train
    output logic             dirOut,       // travel direction
    output logic             devClear,     // deviation-counter clear
    output logic             homeReqFlag,  // home return requested
    output logic             homeCompFlag  // home return complete
);
    localparam int MSW = $clog2(MS_CYC);
    localparam int CLW = $clog2(CLEAR_CYC);
    generate
        if (MS_CYC < 2 || CLEAR_CYC < 2) begin : g_chk
            $error("hrs: MS_CYC and CLEAR_CYC must be at least 2");
        end
    endgenerate
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hrs_state_t        state_q;
    hrs_method_t       meth_q;
    logic              dir_q, limEn_q, rev_q;
    logic [SPD_W-1:0]  homeSpd_q, creepSpd_q, biasSpd_q, accStep_q, stopStep_q, spd_q;
    logic [15:0]       dwell_q, dwellCnt_q, errCode_q;
    logic              dogSeen_q, dogOff_q, halted_q;
    logic              dogPrev_q, zeroPrev_q;
    logic [MSW-1:0]    msCnt_q;
    logic              msTick_q;
    logic [CLW-1:0]    clrCnt_q;
    logic [ACC_W-1:0]  acc_q;
    logic [31:0]       pos_q, travel_q;
    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    logic isDog, idle, run, moving, dogRise, dogFall, zeroRise;
    logic homeLim, oppLim, stopCause, evStart, evErr, evRetry, evDone, evStopped;
    logic [SPD_W:0] stopFloor;
    logic [1:0]     startMeth;
    always_comb begin
        isDog     = (meth_q == M_DOG);
        idle      = (state_q == S_IDLE);
        run       = state_q inside {S_FAST, S_DECEL, S_CREEP};
        moving    = run || state_q inside {S_RETRY, S_HALT};
        dogRise   = sensIn.dog && !dogPrev_q;
        dogFall   = !sensIn.dog && dogPrev_q;
        zeroRise  = sensIn.zero && !zeroPrev_q;
        homeLim   = limEn_q && (dir_q ? !sensIn.loLim : !sensIn.upLim);
        oppLim    = limEn_q && (dir_q ? !sensIn.upLim : !sensIn.loLim);
        evStart   = idle && regWr && regAddr == REG_CTRL && regWdata[CTRL_START];
        startMeth = regWdata[CTRL_METH +: 2]; // method carried by the starting write
        evErr     = evStart && ((startMeth == M_STOP2 && sensIn.zero) || startMeth == 2'h3);
        evRetry   = state_q == S_FAST && isDog && !rev_q && homeLim;
        stopCause = (regWr && regAddr == REG_CTRL && regWdata[CTRL_STOP]) || sensIn.progStop
                    || !sensIn.ready || oppLim
                    || (homeLim && !rev_q && state_q != S_RETRY && !evRetry);
        stopFloor = {1'b0, biasSpd_q} + {1'b0, stopStep_q};
        evStopped = state_q inside {S_RETRY, S_HALT} && msTick_q && {1'b0, spd_q} <= stopFloor;
        evDone    = 1'b0;
        if (state_q inside {S_DECEL, S_CREEP}) begin
            case (meth_q)
                M_DOG:   evDone = dogOff_q && zeroRise;
                M_STOP1: evDone = dogSeen_q && dwellCnt_q >= dwell_q;
                M_STOP2: evDone = zeroRise;
                default: evDone = 1'b0;
            endcase
        end
    end
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q  <= S_IDLE;
            rev_q    <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: if (evStart && !evErr) begin
                    rev_q    <= 1'b0;
                    halted_q <= 1'b0;
                    state_q  <= sensIn.dog ? S_CREEP : S_FAST;
                end
                S_FAST: begin
                    if (stopCause) state_q <= S_HALT;
                    else if (evRetry || (rev_q && dogFall)) state_q <= S_RETRY;
                    else if (!rev_q && dogRise) state_q <= S_DECEL;
                end
                S_DECEL: begin
                    if (stopCause) state_q <= S_HALT;
                    else if (evDone) state_q <= S_CLEAR;
                    else if (spd_q == creepSpd_q) state_q <= S_CREEP;
                end
                S_CREEP: begin
                    if (stopCause) state_q <= S_HALT;
                    else if (evDone) state_q <= S_CLEAR;
                end
                S_RETRY: begin
                    if (stopCause) state_q <= S_HALT;
                    else if (evStopped) begin
                        rev_q   <= !rev_q;
                        state_q <= S_FAST;
                    end
                end
                S_HALT: if (evStopped) begin
                    halted_q <= 1'b1;
                    state_q  <= S_IDLE;
                end
                S_CLEAR: if (clrCnt_q == CLW'(CLEAR_CYC - 1)) state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // speed profile, stepped once a millisecond
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            spd_q <= '0;
        end else if (evStart && !evErr) begin
            spd_q <= sensIn.dog ? creepSpd_q : biasSpd_q;
        end else if (evDone || evStopped || !moving) begin
            spd_q <= '0;
        end else if (evRetry || (stopCause && state_q != S_HALT)) begin
            spd_q <= spd_q; // a lasting stop cause must not freeze the halt ramp
        end else if (msTick_q) begin
            case (state_q)
                S_FAST: if (spd_q < homeSpd_q)
                    spd_q <= (homeSpd_q - spd_q > accStep_q) ? spd_q + accStep_q : homeSpd_q;
                S_DECEL: if (spd_q > creepSpd_q)
                    spd_q <= (spd_q - creepSpd_q > accStep_q) ? spd_q - accStep_q : creepSpd_q;
                S_RETRY, S_HALT: spd_q <= spd_q - stopStep_q;
                default: spd_q <= spd_q;
            endcase
        end
    end
    // ------------------------------------------------------------
    // dog tracking and dwell count
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dogPrev_q  <= 1'b0;
            zeroPrev_q <= 1'b0;
            dogSeen_q  <= 1'b0;
            dogOff_q   <= 1'b0;
            dwellCnt_q <= '0;
        end else begin
            dogPrev_q  <= sensIn.dog;
            zeroPrev_q <= sensIn.zero;
            if (evStart) begin
                dogSeen_q  <= sensIn.dog;
                dogOff_q   <= 1'b0;
                dwellCnt_q <= '0;
            end else if (run && !rev_q) begin
                if (dogRise) dogSeen_q <= 1'b1;
                if (dogFall && dogSeen_q) dogOff_q <= 1'b1;
                if (dogSeen_q && msTick_q && dwellCnt_q != 16'hffff) dwellCnt_q <= dwellCnt_q + 16'h1;
            end
        end
    end
    // ------------------------------------------------------------
    // millisecond divider and clear timer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            msCnt_q  <= '0;
            msTick_q <= 1'b0;
        end else begin
            msTick_q <= (msCnt_q == MSW'(MS_CYC - 1));
            msCnt_q  <= (msCnt_q == MSW'(MS_CYC - 1)) ? '0 : msCnt_q + MSW'(1);
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            clrCnt_q     <= '0;
            devClear     <= 1'b0;
            homeReqFlag  <= 1'b1;
            homeCompFlag <= 1'b0;
        end else begin
            clrCnt_q <= (state_q == S_CLEAR) ? clrCnt_q + CLW'(1) : '0;
            if (evDone && !stopCause) devClear <= 1'b1;
            else if (state_q == S_CLEAR && clrCnt_q == CLW'(CLEAR_CYC - 1)) begin
                devClear     <= 1'b0;
                homeCompFlag <= 1'b1;
                homeReqFlag  <= 1'b0;
            end
            if (evStart && !evErr) begin
                homeReqFlag  <= 1'b1;
                homeCompFlag <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // pulse generator
    // ------------------------------------------------------------
    logic [ACC_W-1:0] accSum;
    always_comb accSum = acc_q + ACC_W'({spd_q, 1'b0});
    always_ff @(posedge core_clk) begin
        if (srst || !moving || spd_q == '0) begin
            acc_q    <= '0;
            pulseOut <= 1'b0;
        end else if (accSum >= ACC_W'(CLK_HZ)) begin
            acc_q    <= accSum - ACC_W'(CLK_HZ);
            pulseOut <= !pulseOut;
        end else begin
            acc_q <= accSum;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pos_q    <= '0;
            travel_q <= '0;
            dirOut   <= 1'b0;
        end else begin
            dirOut <= dir_q ^ rev_q;
            if (evStart || (run && !rev_q && dogRise)) travel_q <= '0;
            if (moving && spd_q != '0 && !pulseOut && accSum >= ACC_W'(CLK_HZ)) begin
                pos_q <= dirOut ? pos_q - 32'h1 : pos_q + 32'h1;
                if (dogSeen_q && !rev_q) travel_q <= travel_q + 32'h1;
            end
        end
    end
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meth_q     <= M_DOG;
            dir_q      <= 1'b0;
            limEn_q    <= 1'b0;
            homeSpd_q  <= HOME_RST;
            creepSpd_q <= CREEP_RST;
            biasSpd_q  <= BIAS_RST;
            accStep_q  <= ACC_RST;
            stopStep_q <= STOPST_RST;
            dwell_q    <= DWELL_RST;
        end else if (regWr && idle) begin
            case (regAddr)
                REG_CTRL: begin
                    meth_q  <= hrs_method_t'(regWdata[CTRL_METH +: 2]);
                    dir_q   <= regWdata[CTRL_DIR];
                    limEn_q <= regWdata[CTRL_LIMEN];
                end
                REG_HOME:   homeSpd_q  <= regWdata[SPD_W-1:0];
                REG_CREEP:  creepSpd_q <= regWdata[SPD_W-1:0];
                REG_BIAS:   biasSpd_q  <= regWdata[SPD_W-1:0];
                REG_ACC:    accStep_q  <= regWdata[SPD_W-1:0];
                REG_STOPST: stopStep_q <= regWdata[SPD_W-1:0];
                REG_DWELL:  dwell_q    <= regWdata[15:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) errCode_q <= '0;
        else if (evErr) errCode_q <= (startMeth == M_STOP2) ? ERR_ZERO_ON : ERR_METHOD;
        else if (regWr && regAddr == REG_ERR) errCode_q <= '0;
    end
    always_ff @(posedge core_clk) begin
        if (srst || !regRd) regRdata <= '0;
        else begin
            case (regAddr)
                REG_CTRL:   regRdata <= {26'h0, limEn_q, dir_q, meth_q, 2'h0};
                REG_HOME:   regRdata <= {14'h0, homeSpd_q};
                REG_CREEP:  regRdata <= {14'h0, creepSpd_q};
                REG_BIAS:   regRdata <= {14'h0, biasSpd_q};
                REG_ACC:    regRdata <= {14'h0, accStep_q};
                REG_STOPST: regRdata <= {14'h0, stopStep_q};
                REG_DWELL:  regRdata <= {16'h0, dwell_q};
                REG_STATUS: regRdata <= {17'h0, state_q, 4'h0, halted_q, !idle, homeCompFlag, homeReqFlag};
                REG_ERR:    regRdata <= {16'h0, errCode_q};
                REG_SPEED:  regRdata <= {14'h0, spd_q};
                REG_TRAVEL: regRdata <= travel_q;
                REG_POS:    regRdata <= pos_q;
                default:    regRdata <= '0;
            endcase
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    int hlpClr_q;
    always_ff @(posedge core_clk) hlpClr_q <= (srst || !devClear) ? 0 : hlpClr_q + 1;
    property p_clrLen;
        $fell(devClear) |-> hlpClr_q == CLEAR_CYC && homeCompFlag && !homeReqFlag;
    endproperty
    a_clrLen: assert property (p_clrLen) else $error("clear pulse length or flags wrong");
    property p_dogZero;
        isDog && state_q inside {S_DECEL, S_CREEP} && dogOff_q && zeroRise && !stopCause
            |=> state_q == S_CLEAR && spd_q == '0 && devClear;
    endproperty
    a_dogZero: assert property (p_dogZero) else $error("zero after dog release did not stop");
    property p_retry;
        state_q == S_FAST && isDog && !rev_q && homeLim && !stopCause |=> state_q == S_RETRY;
    endproperty
    a_retry: assert property (p_retry) else $error("retry not started at home limit");
    property p_oppLim;
        run && oppLim |=> state_q == S_HALT;
    endproperty
    a_oppLim: assert property (p_oppLim) else $error("opposite limit did not halt");
    property p_dogStart;
        evStart && !evErr && sensIn.dog |=> state_q == S_CREEP && spd_q == creepSpd_q;
    endproperty
    a_dogStart: assert property (p_dogStart) else $error("start on dog not at creep");
    property p_start;
        evStart && !evErr && !sensIn.dog |=> state_q == S_FAST && spd_q == biasSpd_q ##1 spd_q <= homeSpd_q;
    endproperty
    a_start: assert property (p_start) else $error("start ramp wrong");
    property p_dogOn;
        state_q == S_FAST && !rev_q && dogRise && !stopCause && !evRetry |=> state_q == S_DECEL;
    endproperty
    a_dogOn: assert property (p_dogOn) else $error("dog on did not decelerate");
    property p_dwell;
        meth_q == M_STOP1 && state_q inside {S_DECEL, S_CREEP} && dogSeen_q && dwellCnt_q >= dwell_q
            && !stopCause |=> state_q == S_CLEAR ##1 pulseOut == 1'b0;
    endproperty
    a_dwell: assert property (p_dwell) else $error("dwell expiry did not complete");
    property p_noRetry;
        !isDog |-> state_q != S_RETRY;
    endproperty
    a_noRetry: assert property (p_noRetry) else $error("retry in stopper method");
    property p_stp2;
        meth_q == M_STOP2 && state_q inside {S_DECEL, S_CREEP} && zeroRise && !stopCause
            |=> state_q == S_CLEAR && devClear;
    endproperty
    a_stp2: assert property (p_stp2) else $error("stopper-2 zero did not complete");
    property p_stopStep;
        state_q == S_HALT && msTick_q && !evStopped |=> spd_q == $past(spd_q) - $past(stopStep_q);
    endproperty
    a_stopStep: assert property (p_stopStep) else $error("stop deceleration step wrong");
    property p_zeroErr;
        evStart && startMeth == M_STOP2 && sensIn.zero |=> errCode_q == ERR_ZERO_ON && idle;
    endproperty
    a_zeroErr: assert property (p_zeroErr) else $error("zero-on start not refused");
    c_dogDone:  cover property (isDog && $fell(devClear));
    c_dwellEnd: cover property (meth_q == M_STOP1 && $rose(devClear));
    c_retry:    cover property (state_q == S_RETRY ##1 state_q == S_FAST);
    c_zeroErr:  cover property (evErr);
endmodule : hrs_home_return_sequencer

// File: hw/hrs_pkg.sv
// hrs_pkg: constants, register map and types for the home-return sequencer
// assumes a 50 MHz core clock and a one-cycle-latency register port
package hrs_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1_000_000;
    localparam int CLEAR_MS      = 10;
    localparam int MS_CYC_DEF    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC_DEF = CLEAR_MS * MS_CYC_DEF;
    localparam int SPD_W         = 18;
    localparam int ACC_W         = 27;
    // ------------------------------------------------------------
    // register word indices
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_HOME   = 4'h1;
    localparam logic [3:0] REG_CREEP  = 4'h2;
    localparam logic [3:0] REG_BIAS   = 4'h3;
    localparam logic [3:0] REG_ACC    = 4'h4;
    localparam logic [3:0] REG_STOPST = 4'h5;
    localparam logic [3:0] REG_DWELL  = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_ERR    = 4'h8;
    localparam logic [3:0] REG_SPEED  = 4'h9;
    localparam logic [3:0] REG_TRAVEL = 4'ha;
    localparam logic [3:0] REG_POS    = 4'hb;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int CTRL_METH  = 2;
    localparam int CTRL_DIR   = 4;
    localparam int CTRL_LIMEN = 5;
    localparam int ST_REQ     = 0;
    localparam int ST_COMP    = 1;
    localparam int ST_BUSY    = 2;
    localparam int ST_HALT    = 3;
    localparam int ST_STATE   = 8;
    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [SPD_W-1:0] HOME_RST   = 18'h02710;
    localparam logic [SPD_W-1:0] CREEP_RST  = 18'h007d0;
    localparam logic [SPD_W-1:0] BIAS_RST   = 18'h00064;
    localparam logic [SPD_W-1:0] ACC_RST    = 18'h0001e;
    localparam logic [SPD_W-1:0] STOPST_RST = 18'h00064;
    localparam logic [15:0]      DWELL_RST  = 16'h01f4;
    localparam logic [15:0]      ERR_ZERO_ON = 16'h04b0;
    localparam logic [15:0]      ERR_METHOD  = 16'h0001;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        M_DOG   = 2'h0,
        M_STOP1 = 2'h1,
        M_STOP2 = 2'h2
    } hrs_method_t;
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_FAST  = 7'h02,
        S_DECEL = 7'h04,
        S_CREEP = 7'h08,
        S_RETRY = 7'h10,
        S_HALT  = 7'h20,
        S_CLEAR = 7'h40
    } hrs_state_t;
    typedef struct packed {
        logic dog;
        logic zero;
        logic upLim;
        logic loLim;
        logic ready;
        logic progStop;
    } hrs_sens_t;
endpackage : hrs_pkg

// File: bench/hrs_drive_model.sv
// hrs_drive_model: drive unit and sensors seen by the sequencer
// assumes the bench commands sensor levels; drive always ready
`timescale 1ns/10ps
module hrs_drive_model
    import hrs_pkg::*;
(
    input  wire logic        core_clk, // clock
    input  wire logic        srst,     // reset
    input  wire logic        pulseOut, // pulse train
    input  wire logic        devClear, // deviation clear
    input  wire logic [3:0]  cmd,      // dog, zero, upLim, loLim
    output hrs_sens_t        sensIn,   // sensor levels
    output logic      [15:0] pulseCnt  // pulses since clear
);
    logic pulse_q;
    // zero from an external switch, ready high, no program stop
    assign sensIn = {cmd, 2'b10};
    always_ff @(posedge core_clk) begin
        pulse_q <= pulseOut;
        if (srst || devClear) begin
            pulseCnt <= 16'h0000;
        end else if (pulseOut && !pulse_q) begin
            pulseCnt <= pulseCnt + 16'h0001;
        end
    end
endmodule : hrs_drive_model

// File: bench/hrs_home_return_sequencer_tb.sv
// hrs_home_return_sequencer_tb: self-checking bench of the sequencer
// assumes shortened ms and clear counts; sensors via the drive model
`timescale 1ns/10ps
module hrs_home_return_sequencer_tb
    import hrs_pkg::*;
;
    logic        core_clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [3:0]  regAddr = 4'h0, cmd = 4'h3;
    logic [31:0] regWdata = 32'h0, regRdata, rdv;
    logic        pulseOut, dirOut, devClear, homeReqFlag, homeCompFlag;
    logic [15:0] pulseCnt;
    hrs_sens_t   sensIn;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    hrs_home_return_sequencer #(.MS_CYC(20), .CLEAR_CYC(50)) i_hrs_home_return_sequencer (.core_clk(core_clk),
        .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .sensIn(sensIn), .pulseOut(pulseOut), .dirOut(dirOut), .devClear(devClear), .homeReqFlag(homeReqFlag),
        .homeCompFlag(homeCompFlag));
    hrs_drive_model i_hrs_drive_model (.core_clk(core_clk), .srst(srst), .pulseOut(pulseOut),
        .devClear(devClear), .cmd(cmd), .sensIn(sensIn), .pulseCnt(pulseCnt));
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // bus and checking
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        rdv = regRdata;
    endtask : rd
    task automatic st(input hrs_state_t s);
        rd(REG_STATUS);
        chk({25'h0, rdv[14:8]}, {25'h0, s});
    endtask : st
    // sensors set, then ctrl written, then time to reach home speed
    task automatic go(input logic [3:0] c, input logic [31:0] ctrl);
        @(posedge core_clk);
        cmd <= c;
        wr(REG_CTRL, ctrl);
        repeat (400) @(posedge core_clk);
    endtask : go
    task automatic sens(input logic [3:0] c);
        @(posedge core_clk);
        cmd <= c;
        repeat (3) @(posedge core_clk);
    endtask : sens
    task automatic finish_clear(input int maxw);
        int n;
        n = 0;
        while (devClear !== 1'b1 && n < maxw) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (devClear === 1'b1) begin
            @(negedge core_clk);
            n++;
        end
        chk(n, 50);
        chk({homeCompFlag, homeReqFlag}, 2'b10);
        repeat (400) @(negedge core_clk);
        chk(pulseCnt, 16'h0000);
        sens(4'h3);
    endtask : finish_clear
    task automatic halt_out(input hrs_state_t s);
        st(s);
        wr(REG_CTRL, 32'h2);
        repeat (200) @(posedge core_clk);
        rd(REG_STATUS);
        chk({rdv[14:8], rdv[3]}, {S_IDLE, 1'b1});
        sens(4'h3);
    endtask : halt_out
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_dog();
        go(4'h3, 32'h1);
        chk({dirOut, homeCompFlag, homeReqFlag}, 3'b001);
        rd(REG_SPEED);
        chk(rdv, 32'h3d090);
        chk(pulseCnt != 16'h0, 1);
        sens(4'hb);
        st(S_DECEL);
        repeat (400) @(posedge core_clk);
        st(S_CREEP);
        rd(REG_SPEED);
        chk(rdv, 32'h249f0);
        sens(4'h3);
        cmd <= 4'h7;
        finish_clear(5);
        $display("t_dog done");
    endtask : t_dog
    task automatic t_short_dog();
        go(4'h3, 32'h1);
        sens(4'hb);
        sens(4'h3);
        st(S_DECEL);
        cmd <= 4'h7;
        finish_clear(5);
        go(4'hb, 32'h1);
        st(S_CREEP);
        sens(4'h3);
        cmd <= 4'h7;
        finish_clear(5);
        $display("t_short_dog done");
    endtask : t_short_dog
    task automatic t_stoppers();
        go(4'h7, 32'h9);
        rd(REG_ERR);
        chk(rdv, 32'h4b0);
        st(S_IDLE);
        wr(REG_ERR, 32'h0);
        go(4'hb, 32'h9);
        st(S_CREEP);
        cmd <= 4'hf;
        finish_clear(5);
        wr(REG_DWELL, 32'h3);
        go(4'h3, 32'h5);
        cmd <= 4'hb;
        finish_clear(90);
        $display("t_stoppers done");
    endtask : t_stoppers
    task automatic t_stops();
        go(4'h3, 32'h1);
        halt_out(S_FAST);
        go(4'h3, 32'h21);
        sens(4'h2);
        halt_out(S_HALT);
        go(4'h3, 32'h21);
        sens(4'h1);
        halt_out(S_RETRY);
        go(4'h3, 32'h25);
        sens(4'h1);
        halt_out(S_HALT);
        $display("t_stops done");
    endtask : t_stops
    task automatic test_done();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        chk({homeCompFlag, homeReqFlag, devClear}, 3'b010);
        rd(4'hf);
        chk(rdv, 32'h0);
        wr(REG_HOME, 32'h3d090);
        wr(REG_CREEP, 32'h249f0);
        wr(REG_BIAS, 32'h1e848);
        wr(REG_ACC, 32'h2710);
        wr(REG_STOPST, 32'hc350);
        t_dog();
        t_short_dog();
        t_stoppers();
        t_stops();
        test_done();
    end
endmodule : hrs_home_return_sequencer_tb
